// ==== rtl/ibe_pkg.sv ====
// Constants, state codes and reference reload values of the two-wire master bit engine.
// Assumes one 100 MHz core clock from which the quarter phases are counted.
package ibe_pkg;

	// Core clock and quarter-phase timing
	localparam int         IBE_CLK_PERIOD_NS = 10;
	localparam int         IBE_QPH_N         = 4;
	localparam logic [1:0] IBE_Q2            = 2'h1;
	localparam logic [1:0] IBE_Q4            = 2'h3;
	localparam logic [1:0] IBE_QPH_RST       = 2'h0;

	// Rate counter
	localparam int         IBE_RELOAD_W      = 7;
	localparam int         IBE_RS_RELOAD_W   = 6;
	localparam logic [6:0] IBE_CNT_RST       = 7'h00;
	// Reference reloads at a 10 MHz instruction rate: two rollovers make one clock period
	localparam logic [6:0] IBE_RELOAD_400K   = 7'h19;
	localparam logic [6:0] IBE_RELOAD_100K   = 7'h64;

	// Byte framing
	localparam int         IBE_BYTE_W        = 8;
	localparam logic [3:0] IBE_BIT_RST       = 4'h0;
	localparam logic [3:0] IBE_BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] IBE_BIT_ACK       = 4'h8;

	// Buffer in front of the shift register
	localparam int         IBE_BUF_DEPTH     = 2;

	typedef enum logic [10:0] {
		IBE_S_IDLE    = 11'h001,
		IBE_S_ST_WAIT = 11'h002,
		IBE_S_ST_HOLD = 11'h004,
		IBE_S_RS_LOW  = 11'h008,
		IBE_S_RS_SDAH = 11'h010,
		IBE_S_RS_REL  = 11'h020,
		IBE_S_RS_HIGH = 11'h040,
		IBE_S_RS_SDAL = 11'h080,
		IBE_S_TX_LOW  = 11'h100,
		IBE_S_TX_REL  = 11'h200,
		IBE_S_TX_HIGH = 11'h400
	} ibe_state_t;

endpackage : ibe_pkg

// ==== rtl/ibe_stream_if.sv ====
// Valid/ready byte stream between the engine and its buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface ibe_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : ibe_stream_if

// ==== rtl/ibe_fifo2.sv ====
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module ibe_fifo2
	import ibe_pkg::*;
#(
	parameter int W     = IBE_BYTE_W,
	parameter int DEPTH = IBE_BUF_DEPTH
) (
	// Clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	// Streams
	ibe_stream_if.snk   wr,
	ibe_stream_if.src   rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	wire           push;
	wire           pull;
	wire [AW-1:0]  wp_nxt;
	wire [AW-1:0]  rp_nxt;

	assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
	assign rd.valid = (cnt_r != '0);
	assign rd.data  = mem_r[rp_r];
	assign push     = wr.valid & wr.ready;
	assign pull     = rd.valid & rd.ready;
	assign wp_nxt   = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
	assign rp_nxt   = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_r[wp_r] <= wr.data;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= wp_nxt;
			if (pull)
				rp_r <= rp_nxt;
			if (push && !pull)
				cnt_r <= cnt_r + (AW+1)'(1);
			else if (pull && !push)
				cnt_r <= cnt_r - (AW+1)'(1);
		end
	end

endmodule : ibe_fifo2

// ==== rtl/ibe_engine.sv ====
// Master bit engine of a two-wire serial port: rate counter, start, repeated start, transmit.
// Assumes open-drain pads with pull-ups outside; requests and clears come from core logic.
`timescale 1ns/10ps
module ibe_engine
	import ibe_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Rate setting
	input  wire logic [IBE_RELOAD_W-1:0] reload_i,
	// Control requests and flag clears
	input  wire logic                    start_req_i,
	input  wire logic                    restart_req_i,
	input  wire logic                    event_clr_i,
	input  wire logic                    bcl_clr_i,
	input  wire logic                    write_collision_flag_clr_i,
	input  wire logic                    start_det_clr_i,
	// Transmit byte stream
	input  wire logic                    tx_valid_i,
	input  wire logic [IBE_BYTE_W-1:0]   tx_data_i,
	output logic                         tx_ready_o,
	// Status
	output logic                         start_req_o,
	output logic                         restart_req_o,
	output logic                         buf_full_o,
	output logic                         ack_status_o,
	output logic                         event_flag_o,
	output logic                         bcl_flag_o,
	output logic                         write_collision_flag_flag_o,
	output logic                         start_det_o,
	// Two-wire pins
	input  wire logic                    scl_i,
	output logic                         scl_o,
	output logic                         scl_oe_n_o,
	input  wire logic                    sda_i,
	output logic                         sda_o,
	output logic                         sda_oe_n_o
);

	ibe_state_t              state_r;
	ibe_state_t              state_nxt;
	logic [1:0]              qph_r;
	logic [IBE_RELOAD_W-1:0] brg_cnt_r;
	logic                    brg_run_r;
	logic                    brg_load;
	logic [IBE_RELOAD_W-1:0] brg_val;
	logic [1:0]              pin_meta_r;
	logic [1:0]              pin_sync_r;
	logic                    scl_drv_r;
	logic                    scl_drv_nxt;
	logic                    sda_drv_r;
	logic                    sda_drv_nxt;
	logic [IBE_BYTE_W-1:0]   shift_r;
	logic [3:0]              bit_cnt_r;
	logic                    start_req_r;
	logic                    restart_req_r;
	logic                    bf_r;
	logic                    ack_r;
	logic                    event_r;
	logic                    bcl_r;
	logic                    write_collision_flag_r;
	logic                    start_det_r;
	logic                    set_sdet;
	logic                    set_bcl;
	logic                    set_evt;
	logic                    end_start;
	logic                    end_restart;
	logic                    pop;
	logic                    bit_step;
	logic                    ack_take;
	wire                     tick;
	wire                     brg_to;
	wire                     scl_s;
	wire                     sda_s;
	wire                     seq_busy;
	wire                     wr_take;
	wire                     wr_refused;
	wire                     bf_clr;

	ibe_stream_if #(.W(IBE_BYTE_W)) wr_if ();
	ibe_stream_if #(.W(IBE_BYTE_W)) rd_if ();

	// Pin synchronisers; only the second stage is read
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_meta_r <= 2'h3;
			pin_sync_r <= 2'h3;
		end
		else
		begin
			pin_meta_r <= {scl_i, sda_i};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign scl_s = pin_sync_r[1];
	assign sda_s = pin_sync_r[0];

	// Quarter phases: two ticks per instruction cycle of four clocks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			qph_r <= IBE_QPH_RST;
		else
			qph_r <= qph_r + 2'h1;
	end

	assign tick   = (qph_r == IBE_Q2) | (qph_r == IBE_Q4);
	assign brg_to = brg_run_r & tick & (brg_cnt_r == IBE_CNT_RST);

	// Each timeout toggles one half of the clock period, so a period is two rollovers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brg_cnt_r <= IBE_CNT_RST;
			brg_run_r <= 1'b0;
		end
		else if (brg_load)
		begin
			brg_cnt_r <= brg_val;
			brg_run_r <= 1'b1;
		end
		else if (brg_to)
			brg_run_r <= 1'b0;
		else if (brg_run_r && tick)
			brg_cnt_r <= brg_cnt_r - 7'h01;
	end

	// Buffer path; writes during a start sequence are refused, not queued
	assign seq_busy    = start_req_r | restart_req_r;
	assign wr_if.valid = tx_valid_i & ~seq_busy;
	assign wr_if.data  = tx_data_i;
	assign tx_ready_o  = seq_busy | wr_if.ready;
	assign wr_take     = wr_if.valid & wr_if.ready;
	assign wr_refused  = tx_valid_i & seq_busy;
	assign rd_if.ready = pop;

	ibe_fifo2 #(
		.W     (IBE_BYTE_W),
		.DEPTH (IBE_BUF_DEPTH)
	) u_buf (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.wr    (wr_if),
		.rd    (rd_if)
	);

	// Sequencer
	always_comb
	begin
		state_nxt   = state_r;
		scl_drv_nxt = scl_drv_r;
		sda_drv_nxt = sda_drv_r;
		brg_load    = 1'b0;
		brg_val     = reload_i;
		set_sdet    = 1'b0;
		set_bcl     = 1'b0;
		set_evt     = 1'b0;
		end_start   = 1'b0;
		end_restart = 1'b0;
		pop         = 1'b0;
		bit_step    = 1'b0;
		ack_take    = 1'b0;
		case (state_r)
			IBE_S_IDLE:
			begin
				// Lines keep their last level while idle
				if (start_req_r)
				begin
					if (scl_s && sda_s)
					begin
						brg_load  = 1'b1;
						state_nxt = IBE_S_ST_WAIT;
					end
					else
					begin
						set_bcl   = 1'b1;
						end_start = 1'b1;
					end
				end
				else if (restart_req_r)
				begin
					scl_drv_nxt = 1'b1;
					state_nxt   = IBE_S_RS_LOW;
				end
				else if (rd_if.valid)
				begin
					pop         = 1'b1;
					scl_drv_nxt = 1'b1;
					brg_load    = 1'b1;
					state_nxt   = IBE_S_TX_LOW;
				end
			end
			IBE_S_ST_WAIT:
			begin
				if (!scl_s || (brg_to && !sda_s))
				begin
					set_bcl   = 1'b1;
					end_start = 1'b1;
					state_nxt = IBE_S_IDLE;
				end
				else if (brg_to)
				begin
					sda_drv_nxt = 1'b1;
					set_sdet    = 1'b1;
					brg_load    = 1'b1;
					state_nxt   = IBE_S_ST_HOLD;
				end
			end
			IBE_S_ST_HOLD:
			begin
				if (brg_to)
				begin
					end_start = 1'b1;
					set_evt   = 1'b1;
					state_nxt = IBE_S_IDLE;
				end
			end
			IBE_S_RS_LOW:
			begin
				if (!scl_s)
				begin
					brg_val     = {1'b0, reload_i[IBE_RS_RELOAD_W-1:0]};
					brg_load    = 1'b1;
					sda_drv_nxt = 1'b0;
					state_nxt   = IBE_S_RS_SDAH;
				end
			end
			IBE_S_RS_SDAH:
			begin
				if (brg_to && sda_s)
				begin
					scl_drv_nxt = 1'b0;
					state_nxt   = IBE_S_RS_REL;
				end
				else if (brg_to)
				begin
					set_bcl     = 1'b1;
					end_restart = 1'b1;
					scl_drv_nxt = 1'b0;
					state_nxt   = IBE_S_IDLE;
				end
			end
			IBE_S_RS_REL:
			begin
				// Counter stays halted while another device stretches the clock
				if (scl_s && !sda_s)
				begin
					set_bcl     = 1'b1;
					end_restart = 1'b1;
					state_nxt   = IBE_S_IDLE;
				end
				else if (scl_s)
				begin
					brg_load  = 1'b1;
					state_nxt = IBE_S_RS_HIGH;
				end
			end
			IBE_S_RS_HIGH:
			begin
				if (!scl_s)
				begin
					set_bcl     = 1'b1;
					end_restart = 1'b1;
					state_nxt   = IBE_S_IDLE;
				end
				else if (brg_to)
				begin
					sda_drv_nxt = 1'b1;
					set_sdet    = 1'b1;
					brg_load    = 1'b1;
					state_nxt   = IBE_S_RS_SDAL;
				end
			end
			IBE_S_RS_SDAL:
			begin
				if (brg_to)
				begin
					end_restart = 1'b1;
					set_evt     = 1'b1;
					state_nxt   = IBE_S_IDLE;
				end
			end
			IBE_S_TX_LOW:
			begin
				// Data moves a clock after the fall, never while the clock is high
				sda_drv_nxt = (bit_cnt_r == IBE_BIT_ACK) ? 1'b0
				            : ~shift_r[IBE_BYTE_W-1];
				if (brg_to)
				begin
					scl_drv_nxt = 1'b0;
					state_nxt   = IBE_S_TX_REL;
				end
			end
			IBE_S_TX_REL:
			begin
				if (scl_s)
				begin
					brg_load  = 1'b1;
					state_nxt = IBE_S_TX_HIGH;
				end
			end
			IBE_S_TX_HIGH:
			begin
				if (brg_to && (bit_cnt_r == IBE_BIT_ACK))
				begin
					scl_drv_nxt = 1'b1;
					sda_drv_nxt = 1'b0;
					ack_take    = 1'b1;
					set_evt     = 1'b1;
					state_nxt   = IBE_S_IDLE;
				end
				else if (brg_to)
				begin
					scl_drv_nxt = 1'b1;
					bit_step    = 1'b1;
					brg_load    = 1'b1;
					state_nxt   = IBE_S_TX_LOW;
				end
			end
			default:
			begin
				scl_drv_nxt = 1'b0;
				sda_drv_nxt = 1'b0;
				state_nxt   = IBE_S_IDLE;
			end
		endcase
		if (set_bcl)
		begin
			// A lost sequence lets go of both lines
			scl_drv_nxt = 1'b0;
			sda_drv_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r   <= IBE_S_IDLE;
			scl_drv_r <= 1'b0;
			sda_drv_r <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			scl_drv_r <= scl_drv_nxt;
			sda_drv_r <= sda_drv_nxt;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			shift_r   <= '0;
			bit_cnt_r <= IBE_BIT_RST;
		end
		else if (pop)
		begin
			shift_r   <= rd_if.data;
			bit_cnt_r <= IBE_BIT_RST;
		end
		else if (bit_step)
		begin
			shift_r   <= {shift_r[IBE_BYTE_W-2:0], 1'b0};
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	// Requests and sticky flags; a flag set wins over its clear in the same cycle, a request during a busy sequence is dropped
	assign bf_clr = bit_step & (bit_cnt_r == IBE_BIT_LAST_DATA) & ~rd_if.valid;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_req_r   <= 1'b0;
			restart_req_r <= 1'b0;
			bf_r          <= 1'b0;
			ack_r         <= 1'b0;
			event_r       <= 1'b0;
			bcl_r         <= 1'b0;
			write_collision_flag_r        <= 1'b0;
			start_det_r   <= 1'b0;
		end
		else
		begin
			start_req_r   <= (start_req_i & ~seq_busy) | (start_req_r & ~end_start);
			restart_req_r <= (restart_req_i & ~seq_busy & (state_r == IBE_S_IDLE))
			               | (restart_req_r & ~end_restart);
			bf_r          <= wr_take | (bf_r & ~bf_clr);
			if (ack_take)
				ack_r <= sda_s;
			event_r       <= set_evt | (event_r & ~event_clr_i);
			bcl_r         <= set_bcl | (bcl_r & ~bcl_clr_i);
			write_collision_flag_r        <= wr_refused | (write_collision_flag_r & ~write_collision_flag_clr_i);
			start_det_r   <= set_sdet | (start_det_r & ~start_det_clr_i);
		end
	end

	// Outputs; pads only ever pull low
	assign scl_o         = 1'b0;
	assign sda_o         = 1'b0;
	assign scl_oe_n_o    = ~scl_drv_r;
	assign sda_oe_n_o    = ~sda_drv_r;
	assign start_req_o   = start_req_r;
	assign restart_req_o = restart_req_r;
	assign buf_full_o    = bf_r;
	assign ack_status_o  = ack_r;
	assign event_flag_o  = event_r;
	assign bcl_flag_o    = bcl_r;
	assign write_collision_flag_flag_o   = write_collision_flag_r;
	assign start_det_o   = start_det_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_tick_spacing: assert property (tick |=> !tick)
		else $error("rate tick on two adjacent clocks");
	chk_count_halted: assert property (!brg_run_r && !brg_load |=> $stable(brg_cnt_r))
		else $error("halted rate counter moved");
	chk_start_load: assert property (state_r == IBE_S_IDLE && start_req_r && scl_s && sda_s
		|=> state_r == IBE_S_ST_WAIT && brg_cnt_r == $past(reload_i) && brg_run_r)
		else $error("start did not load the counter");
	chk_clock_pause: assert property (state_r == IBE_S_TX_REL && !scl_s
		|=> !brg_run_r && $stable(brg_cnt_r))
		else $error("counter ran while clock held low");
	chk_high_reload: assert property (state_r == IBE_S_TX_REL && scl_s
		|=> state_r == IBE_S_TX_HIGH && brg_cnt_r == $past(reload_i))
		else $error("clock high did not reload counter");
	chk_start_drive: assert property (state_r == IBE_S_ST_WAIT && brg_to && scl_s && sda_s
		|=> sda_drv_r && start_det_r && state_r == IBE_S_ST_HOLD)
		else $error("start timeout did not pull data low");
	chk_start_abort: assert property (state_r == IBE_S_IDLE && start_req_r && !(scl_s && sda_s)
		|=> bcl_r && !start_req_r && state_r == IBE_S_IDLE)
		else $error("start with low line not aborted");
	chk_write_collision_flag_set: assert property (tx_valid_i && seq_busy |=> write_collision_flag_r)
		else $error("refused write left no collision flag");
	chk_req_locked: assert property (seq_busy && start_req_i && !start_req_r |=> !start_req_r)
		else $error("start request taken during sequence");
	chk_restart_ignored: assert property (restart_req_i && !restart_req_r
		&& state_r != IBE_S_IDLE |=> !restart_req_r)
		else $error("restart taken while busy");
	chk_rs_load: assert property (state_r == IBE_S_RS_LOW && !scl_s
		|=> brg_cnt_r == {1'b0, $past(reload_i[IBE_RS_RELOAD_W-1:0])} && !sda_drv_r)
		else $error("restart load used wrong field");
	chk_rs_finish: assert property (state_r == IBE_S_RS_SDAL && brg_to
		|=> event_r && !restart_req_r && sda_drv_r && !brg_run_r)
		else $error("restart end wrong");
	chk_bf_clear: assert property ($fell(bf_r)
		|-> $past(bit_cnt_r) == IBE_BIT_LAST_DATA ##1 !sda_drv_r)
		else $error("buffer full cleared at wrong bit");
	chk_data_steady: assert property (state_r == IBE_S_TX_HIGH |=> $stable(sda_drv_r))
		else $error("data moved while clock high");
	chk_ack_done: assert property (state_r == IBE_S_TX_HIGH && brg_to && bit_cnt_r == IBE_BIT_ACK
		|=> event_r && scl_drv_r && !sda_drv_r && ack_r == $past(sda_s) && state_r == IBE_S_IDLE)
		else $error("ninth clock end wrong");
	chk_open_drain: assert property (!scl_o && !sda_o)
		else $error("pad driven high");

	cov_start_done:   cover property (state_r == IBE_S_ST_HOLD && brg_to);
	cov_restart_done: cover property (state_r == IBE_S_RS_SDAL && brg_to);
	cov_byte_done:    cover property (ack_take);
	cov_collision:    cover property (set_bcl);

endmodule : ibe_engine

// ==== dv/ibe_slave_model.sv ====
// Target device on the two-wire bus: acknowledges and stretches the clock.
// Assumes wired-and lines with pull-ups and one core clock.
`timescale 1ns/10ps
module ibe_slave_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Line levels and behaviour
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       ack_en_i,
	input  wire logic [3:0] stretch_i,
	// Pulls, low active
	output logic            scl_pull_n_o,
	output logic            sda_pull_n_o
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] fcnt;
	logic [3:0] scnt;
	// Only ever pulls low, so released lines rise by the pull-up
	assign sda_pull_n_o = !(ack_en_i && fcnt == 4'h9);
	assign scl_pull_n_o = (scnt == 4'h0);
	always @(posedge clk_i)
	begin
		scl_q <= scl_i;
		sda_q <= sda_i;
		if (rst_i)
		begin
			fcnt <= 4'h0;
			scnt <= 4'h0;
		end
		else if (scl_i && scl_q && sda_q && !sda_i)
			fcnt <= 4'h0;
		else if (!scl_i && scl_q)
		begin
			// Tenth fall is the first fall of the next byte
			fcnt <= (fcnt == 4'h9) ? 4'h1 : fcnt + 4'h1;
			scnt <= stretch_i;
		end
		else if (scnt != 4'h0)
			scnt <= scnt - 4'h1;
	end
endmodule : ibe_slave_model

// ==== dv/tb_i2c_master_bit_engine.sv ====
// Self-checking bench of the bit engine with a stretching, acknowledging target.
// Assumes the engine's pins are open drain with pull-ups on both lines.
`timescale 1ns/10ps
module tb_i2c_master_bit_engine;
	import ibe_pkg::*;
	localparam logic [6:0] RLD = 7'h03;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [6:0] reload_i = RLD;
	logic       start_req_i = 1'b0;
	logic       restart_req_i = 1'b0;
	logic       event_clr_i = 1'b0;
	logic       bcl_clr_i = 1'b0;
	logic       write_collision_flag_clr_i = 1'b0;
	logic       start_det_clr_i = 1'b0;
	logic       tx_valid_i = 1'b0;
	logic [7:0] tx_data_i = 8'h00;
	logic       tx_ready_o, start_req_o, restart_req_o, buf_full_o, ack_status_o;
	logic       event_flag_o, bcl_flag_o, write_collision_flag_flag_o, start_det_o;
	logic       scl_oe_n_o, sda_oe_n_o, slv_scl_n, slv_sda_n;
	logic       tb_sda_n = 1'b1;
	logic       ack_en = 1'b1;
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic [3:0] bitn;
	logic [7:0] sh;
	int         hcnt;
	int         error_cnt = 0;
	int         checks = 0;
	int         seed = 32'h8865;
	logic [7:0] exp_q[$];
	wire        scl_w = scl_oe_n_o & slv_scl_n;
	wire        sda_w = sda_oe_n_o & slv_sda_n & tb_sda_n;

	always #5 clk_i = ~clk_i;

	ibe_engine uut (.clk_i(clk_i), .rst_i(rst_i), .reload_i(reload_i),
		.start_req_i(start_req_i), .restart_req_i(restart_req_i),
		.event_clr_i(event_clr_i), .bcl_clr_i(bcl_clr_i), .write_collision_flag_clr_i(write_collision_flag_clr_i),
		.start_det_clr_i(start_det_clr_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
		.tx_ready_o(tx_ready_o), .start_req_o(start_req_o), .restart_req_o(restart_req_o),
		.buf_full_o(buf_full_o), .ack_status_o(ack_status_o), .event_flag_o(event_flag_o),
		.bcl_flag_o(bcl_flag_o), .write_collision_flag_flag_o(write_collision_flag_flag_o), .start_det_o(start_det_o),
		.scl_i(scl_w), .scl_o(), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(),
		.sda_oe_n_o(sda_oe_n_o));

	ibe_slave_model slave (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
		.ack_en_i(ack_en), .stretch_i(4'hC), .scl_pull_n_o(slv_scl_n),
		.sda_pull_n_o(slv_sda_n));

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask : chk

	task test_done;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task pulse(input logic st, input logic rs, input logic cl);
		@(negedge clk_i);
		start_req_i = st;
		restart_req_i = rs;
		{event_clr_i, bcl_clr_i, write_collision_flag_clr_i, start_det_clr_i} = {4{cl}};
		@(negedge clk_i);
		{start_req_i, restart_req_i, event_clr_i, bcl_clr_i, write_collision_flag_clr_i, start_det_clr_i} = 6'h00;
	endtask : pulse

	// Holds the word until ready stands before a rising edge, then notes it
	task put_byte(input logic [7:0] d);
		@(negedge clk_i);
		tx_valid_i = 1'b1;
		tx_data_i = d;
		for (int i = 0; i < 3000 && tx_ready_o !== 1'b1; i++) @(negedge clk_i);
		chk("tx ready", 8'h01, tx_ready_o);
		@(posedge clk_i);
		exp_q.push_back(d);
		@(negedge clk_i);
		tx_valid_i = 1'b0;
	endtask : put_byte

	task wait_event;
		for (int i = 0; i < 3000 && event_flag_o !== 1'b1; i++) @(negedge clk_i);
		chk("event", 8'h01, event_flag_o);
	endtask : wait_event

	// Wire monitor: bits taken on rising clock, high time measured per bit
	always @(posedge clk_i)
	begin
		scl_q <= scl_w;
		sda_q <= sda_w;
		// Frames cut by a collision are not measured
		if (rst_i || bcl_flag_o || (scl_w && scl_q && sda_q && !sda_w))
			bitn <= 4'h0;
		else if (scl_w && !scl_q)
		begin
			bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
			sh <= {sh[6:0], sda_w};
			hcnt <= 0;
			if (bitn == 4'h7)
			begin
				if (exp_q.size() == 0)
					chk("spare byte", 8'h00, 8'hFF);
				else
					chk("wire byte", exp_q.pop_front(), {sh[6:0], sda_w});
			end
		end
		else if (scl_w)
			hcnt <= hcnt + 1;
		else if (scl_q && bitn != 4'h0)
		begin
			chk("high min", 8'h01, 8'((hcnt + 1) >= 2 * (RLD + 1)));
			chk("high max", 8'h01, 8'((hcnt + 1) <= 2 * (RLD + 1) + 8));
		end
	end

	initial
	begin
		#900000;
		error_cnt++;
		test_done;
	end

	initial
	begin
		repeat (3) @(posedge clk_i);
		@(negedge clk_i) rst_i = 1'b0;
		pulse(1'b1, 1'b0, 1'b0);
		// A write while the start runs is dropped
		@(negedge clk_i) tx_valid_i = 1'b1;
		tx_data_i = 8'hA5;
		@(negedge clk_i) tx_valid_i = 1'b0;
		for (int i = 0; i < 3000 && start_req_o !== 1'b0; i++) @(posedge clk_i);
		@(negedge clk_i);
		chk("start end", 8'h00, start_req_o);
		chk("start det", 8'h01, start_det_o);
		chk("start event", 8'h01, event_flag_o);
		chk("start sda", 8'h00, sda_oe_n_o);
		chk("write_collision_flag", 8'h01, write_collision_flag_flag_o);
		chk("bf after write_collision_flag", 8'h00, buf_full_o);
		pulse(1'b0, 1'b0, 1'b1);
		put_byte(8'($random(seed)));
		put_byte(8'($random(seed)));
		chk("bf set", 8'h01, buf_full_o);
		pulse(1'b0, 1'b1, 1'b0);
		chk("restart busy", 8'h00, restart_req_o);
		wait_event;
		chk("ack first", 8'h00, ack_status_o);
		chk("scl hold", 8'h00, scl_oe_n_o);
		chk("sda free", 8'h01, sda_oe_n_o);
		ack_en = 1'b0;
		pulse(1'b0, 1'b0, 1'b1);
		wait_event;
		chk("nack", 8'h01, ack_status_o);
		chk("bf clear", 8'h00, buf_full_o);
		repeat (40) @(negedge clk_i);
		chk("clock stopped", 8'h00, scl_oe_n_o);
		ack_en = 1'b1;
		pulse(1'b0, 1'b0, 1'b1);
		pulse(1'b0, 1'b1, 1'b0);
		// A start asked for while the restart runs is dropped
		pulse(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 3000 && restart_req_o !== 1'b0; i++) @(posedge clk_i);
		@(negedge clk_i);
		chk("rs end", 8'h00, restart_req_o);
		chk("start locked", 8'h00, start_req_o);
		chk("rs det", 8'h01, start_det_o);
		chk("rs event", 8'h01, event_flag_o);
		chk("rs sda", 8'h00, sda_oe_n_o);
		chk("rs bcl", 8'h00, bcl_flag_o);
		pulse(1'b0, 1'b0, 1'b1);
		put_byte(8'($random(seed)));
		wait_event;
		chk("ack after rs", 8'h00, ack_status_o);
		// Start with a line held low collides
		pulse(1'b0, 1'b0, 1'b1);
		@(negedge clk_i) tb_sda_n = 1'b0;
		pulse(1'b1, 1'b0, 1'b0);
		repeat (8) @(negedge clk_i);
		chk("bcl", 8'h01, bcl_flag_o);
		chk("bcl start off", 8'h00, start_req_o);
		chk("bcl det", 8'h00, start_det_o);
		// Restart with data still held low collides at the first timeout
		pulse(1'b0, 1'b0, 1'b1);
		pulse(1'b0, 1'b1, 1'b0);
		repeat (40) @(negedge clk_i);
		chk("rs collision", 8'h01, bcl_flag_o);
		chk("rs abort", 8'h00, restart_req_o);
		tb_sda_n = 1'b1;
		chk("bytes left", 8'h00, 8'(exp_q.size()));
		test_done;
	end
endmodule : tb_i2c_master_bit_engine
